// >>> logic/pin_qual_pkg.sv
// constants for the pin input qualifier: register map, field positions, filter counts
// assumes a 16-bit data-space register port on the device clock
package pin_qual_pkg;
	// pin vector layout
	localparam int unsigned NUM_PINS = 11;
	localparam int unsigned CAP_LO = 0;
	localparam int unsigned XINT_LO = 6;
	localparam int unsigned ADC_SOC_IDX = 8;
	localparam int unsigned PDP_LO = 9;
	// register offsets
	localparam logic [15:0] SYSTEM_CONTROL_TWO_ADDR = 16'h7019;
	localparam logic [15:0] COMPARE_CONTROL_A_ADDR = 16'h7f00;
	localparam logic [15:0] COMPARE_CONTROL_B_ADDR = 16'h7f01;
	// field positions
	localparam int unsigned WIDTH_SEL_BIT = 6;
	localparam int unsigned HIGHZ_BIT = 4;
	localparam int unsigned PDP_STATUS_BIT = 8;
	localparam logic [7:0] SCR2_WRITABLE = 8'hff;
	// reset values
	localparam logic [7:0] SCR2_RESET = 8'h00;
	// filter lengths in clock edges
	localparam logic [3:0] SHORT_EDGES = 4'h6;
	localparam logic [3:0] LONG_EDGES = 4'hc;
endpackage

// >>> logic/qual_link_if.sv
// carrier between the register front end and the filter bank
// assumes both ends share core_clk
`timescale 1ns/1ps
interface qual_link_if;
	logic long_sel;
	logic [pin_qual_pkg::NUM_PINS-1:0] raw;
	logic [pin_qual_pkg::NUM_PINS-1:0] qual;
	modport front (output long_sel, output raw, input qual);
	modport bank (input long_sel, input raw, output qual);
endinterface

// >>> logic/input_filter_bank.sv
// per-pin synchroniser and stability counter for every qualified pin
// assumes raw pins are sampled on core_clk; ce low freezes all state
`timescale 1ns/1ps
module input_filter_bank (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	// link to front end
	qual_link_if.bank link
);
	logic [3:0] limit;

	assign limit = link.long_sel ? pin_qual_pkg::LONG_EDGES : pin_qual_pkg::SHORT_EDGES;

	genvar i;
	generate
		for (i = 0; i < pin_qual_pkg::NUM_PINS; i++) begin : g_pin
			logic meta;
			logic samp;
			logic [3:0] cnt;
			logic q;
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					meta <= 1'b0;
					samp <= 1'b0;
				end else if (ce) begin
					meta <= link.raw[i];
					samp <= meta;
				end
			end
			// level passes only after limit edges
			always_ff @(posedge core_clk or negedge nrst) begin
				if (!nrst) begin
					cnt <= 4'h0;
					q <= 1'b0;
				end else if (ce) begin
					if (samp == q) begin
						cnt <= 4'h0;
					end else if (cnt >= limit - 4'h1) begin
						// >= keeps a shortened setting from stranding a long count
						cnt <= 4'h0;
						q <= samp;
					end else begin
						cnt <= cnt + 4'h1;
					end
				end
			end
			assign link.qual[i] = q;
		end
	endgenerate
endmodule

// >>> logic/pin_input_qualifier.sv
// pin input qualifier: register front end, filter bank, qualified outputs
// assumes pins and register strobes are synchronous to core_clk
// assumes the internal consumers take the qualified levels on the same clock
//
// Operation
// - capture, interrupt, adc start and drive protect pins are all qualified
// - internal level changes only after 6 or 12 stable edges
// - system control two bit 6 picks 6 edges when clear, 12 when set
// - drive protect levels readable at bit 8 of compare control registers
`timescale 1ns/1ps
module pin_input_qualifier (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic ce,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// raw pins
	input wire logic [5:0] capture_inputs,
	input wire logic [1:0] external_interrupt_inputs,
	input wire logic adc_start_pin,
	input wire logic [1:0] power_drive_protect_inputs,
	// qualified levels to internal logic
	output logic [5:0] capture_qual,
	output logic [1:0] external_interrupt_qual,
	output logic adc_start_qual,
	output logic [1:0] power_drive_protect_qual,
	// system control outputs
	output logic qualifier_width_select,
	output logic ext_memory_highz_control
);
	qual_link_if link ();

	// address decode results
	logic hit_scr2;
	logic hit_cmp_a;
	logic hit_cmp_b;
	logic scr2_wr;
	logic rd_taken;
	logic [7:0] next_scr2;

	// register image; each field is its own flop group
	logic width_sel_q;
	logic highz_q;
	logic [7:0] spare_bits;
	logic [7:0] system_control_two;

	// read source
	typedef enum {
		SEL_NONE,
		SEL_SCR2,
		SEL_CMP_A,
		SEL_CMP_B
	} rd_sel_t;
	rd_sel_t rd_sel;
	logic [15:0] next_rdata;

	// all documented pins enter the filter
	assign link.raw = {power_drive_protect_inputs, adc_start_pin, external_interrupt_inputs, capture_inputs};

	assign link.long_sel = width_sel_q;

	// one shared carrier keeps raw and filtered vectors aligned bit for bit
	input_filter_bank u_bank (
		.core_clk(core_clk),
		.nrst(nrst),
		.ce(ce),
		.link(link)
	);

	// outputs are the filtered flops only
	assign capture_qual = link.qual[pin_qual_pkg::CAP_LO +: 6];
	assign external_interrupt_qual = link.qual[pin_qual_pkg::XINT_LO +: 2];
	assign adc_start_qual = link.qual[pin_qual_pkg::ADC_SOC_IDX];
	assign power_drive_protect_qual = link.qual[pin_qual_pkg::PDP_LO +: 2];

	// address decode; unmapped offsets hit nothing
	always_comb begin
		hit_scr2 = 1'b0;
		hit_cmp_a = 1'b0;
		hit_cmp_b = 1'b0;
		case (reg_addr)
			pin_qual_pkg::SYSTEM_CONTROL_TWO_ADDR: begin
				hit_scr2 = 1'b1;
			end
			pin_qual_pkg::COMPARE_CONTROL_A_ADDR: begin
				hit_cmp_a = 1'b1;
			end
			pin_qual_pkg::COMPARE_CONTROL_B_ADDR: begin
				hit_cmp_b = 1'b1;
			end
			default: begin
				hit_scr2 = 1'b0;
				hit_cmp_a = 1'b0;
				hit_cmp_b = 1'b0;
			end
		endcase
	end

	// strobes only act while the clock enable lets state move
	assign scr2_wr = ce && reg_wr && hit_scr2;
	assign rd_taken = ce && reg_rd;
	// bits above 7 do not exist and are dropped here
	assign next_scr2 = reg_wdata[7:0] & pin_qual_pkg::SCR2_WRITABLE;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			width_sel_q <= pin_qual_pkg::SCR2_RESET[pin_qual_pkg::WIDTH_SEL_BIT];
		end else if (scr2_wr) begin
			width_sel_q <= next_scr2[pin_qual_pkg::WIDTH_SEL_BIT];
		end
	end

	// bit stored as written; keeping it zero is software's duty
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			highz_q <= pin_qual_pkg::SCR2_RESET[pin_qual_pkg::HIGHZ_BIT];
		end else if (scr2_wr) begin
			highz_q <= next_scr2[pin_qual_pkg::HIGHZ_BIT];
		end
	end

	// remaining bits only store and read back
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			spare_bits <= pin_qual_pkg::SCR2_RESET;
		end else if (scr2_wr) begin
			spare_bits <= next_scr2;
		end
	end

	// fields merged back into the readable image
	// merging here keeps the read view in one place as fields are added
	always_comb begin
		system_control_two = spare_bits;
		system_control_two[pin_qual_pkg::WIDTH_SEL_BIT] = width_sel_q;
		system_control_two[pin_qual_pkg::HIGHZ_BIT] = highz_q;
	end

	// control outputs straight from their field flops
	assign qualifier_width_select = width_sel_q;
	assign ext_memory_highz_control = highz_q;

	// one status word per compare control register
	// status shows the filtered level, so a glitch never reaches software
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_status
			logic [15:0] view;
			always_comb begin
				view = 16'h0000;
				view[pin_qual_pkg::PDP_STATUS_BIT] = link.qual[pin_qual_pkg::PDP_LO + ch];
			end
		end
	endgenerate

	// read source select; offsets are distinct, so the order is moot
	always_comb begin
		rd_sel = SEL_NONE;
		if (hit_scr2) begin
			rd_sel = SEL_SCR2;
		end else if (hit_cmp_a) begin
			rd_sel = SEL_CMP_A;
		end else if (hit_cmp_b) begin
			rd_sel = SEL_CMP_B;
		end else begin
			rd_sel = SEL_NONE;
		end
	end

	always_comb begin
		next_rdata = 16'h0000;
		case (rd_sel)
			SEL_SCR2: begin
				next_rdata = {8'h00, system_control_two};
			end
			SEL_CMP_A: begin
				next_rdata = g_status[0].view;
			end
			SEL_CMP_B: begin
				next_rdata = g_status[1].view;
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// valid pulse follows every taken read, mapped or not
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
		end
	end

	// read data holds until the next taken read; unmapped reads return zero
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 16'h0000;
		end else if (rd_taken) begin
			reg_rdata <= next_rdata;
		end
	end
endmodule

// >>> dv/pin_qual_monitor.sv
// assertions on the qualifier top ports
// the bench drops ce for its freeze test; checks are disabled while ce is low
`timescale 1ns/1ps
module pin_qual_monitor(
	input wire logic core_clk, nrst, ce, reg_wr, reg_rd, reg_rvalid, adc_start_pin, adc_start_qual,
	input wire logic qualifier_width_select, ext_memory_highz_control,
	input wire logic [15:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [5:0] capture_inputs, capture_qual,
	input wire logic [1:0] external_interrupt_inputs, external_interrupt_qual,
	input wire logic [1:0] power_drive_protect_inputs, power_drive_protect_qual
);
	wire [10:0] q = {power_drive_protect_qual, adc_start_qual, external_interrupt_qual, capture_qual};
	wire [10:0] p = {power_drive_protect_inputs, adc_start_pin, external_interrupt_inputs, capture_inputs};
	default clocking @(posedge core_clk); endclocking
	// a frozen bank stretches every latency, so checks pause while ce is low
	default disable iff (!nrst || !ce);
	sequence s_on7; (adc_start_pin && qualifier_width_select) [*7]; endsequence
	sequence s_blip; !adc_start_pin [*2] ##1 adc_start_pin [*5]; endsequence
	property p_all; ((q ^ $past(q)) & (q ^ $past(p, 3))) == 11'h000; endproperty
	property p_short; (adc_start_pin && !qualifier_width_select) [*8] |=> adc_start_qual; endproperty
	property p_long; s_on7 ##1 s_on7 |=> adc_start_qual; endproperty
	property p_glitch; s_blip ##1 !adc_start_pin && !adc_start_qual && !qualifier_width_select
		|=> !adc_start_qual [*3]; endproperty
	property p_wsel; reg_wr && reg_addr == pin_qual_pkg::SYSTEM_CONTROL_TWO_ADDR
		|=> qualifier_width_select == $past(reg_wdata[6]) && ext_memory_highz_control == $past(reg_wdata[4]); endproperty
	property p_stat; reg_rd && reg_addr == pin_qual_pkg::COMPARE_CONTROL_B_ADDR
		|=> reg_rvalid && reg_rdata == {7'h00, $past(power_drive_protect_qual[1]), 8'h00}; endproperty
	a_all: assert property (p_all) else $error("qualified level not from settled sample");
	a_short: assert property (p_short) else $error("short filter too slow");
	a_long: assert property (p_long) else $error("long filter too slow");
	a_glitch: assert property (p_glitch) else $error("short glitch passed");
	a_wsel: assert property (p_wsel) else $error("control bits not stored");
	a_stat: assert property (p_stat) else $error("status bit wrong");
endmodule
bind pin_input_qualifier pin_qual_monitor i_pin_qual_monitor(.*);

// >>> dv/pin_driver_model.sv
// outside driver of the eleven qualified pins
// assumes drive is called at a falling edge
`timescale 1ns/1ps
module pin_driver_model(
	input wire logic core_clk,
	output logic [10:0] pins
);
	initial pins = 11'h000;
	task automatic drive(input logic [10:0] v, input int n);
		pins = v;
		repeat (n) @(negedge core_clk);
	endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the pin input qualifier
// assumes one clock; ce held high except while the freeze test drops it
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rvalid;
	logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, rdata, w, lfsr = 16'h1fb1;
	logic [10:0] pins, v, lq = 11'h000, el = 11'h000;
	wire [10:0] q;
	logic [15:0] exp_rd[$];
	logic [10:0] exp_q[$];
	int n_mismatch = 0, checks_done = 0, cyc = 0, n;
	pin_driver_model i_pin_driver_model(.core_clk(core_clk), .pins(pins));
	pin_input_qualifier i_pin_input_qualifier(.core_clk(core_clk), .nrst(nrst), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata),
		.reg_rvalid(rvalid), .capture_inputs(pins[5:0]), .external_interrupt_inputs(pins[7:6]),
		.adc_start_pin(pins[8]), .power_drive_protect_inputs(pins[10:9]), .capture_qual(q[5:0]),
		.external_interrupt_qual(q[7:6]), .adc_start_qual(q[8]), .power_drive_protect_qual(q[10:9]),
		.qualifier_width_select(), .ext_memory_highz_control());
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic bad(input logic [15:0] e, g);
		n_mismatch++;
		$display("BAD t=%0t exp=%h got=%h", $time, e, g);
	endtask
	task automatic cmp_rd(input logic [15:0] e);
		checks_done++;
		if (rdata !== e) bad(e, rdata);
	endtask
	task automatic cmp_q(input logic [10:0] e);
		checks_done++;
		if (q !== e) bad({5'h00, e}, {5'h00, q});
	endtask
	task automatic wr(input logic [15:0] a, d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic rd(input logic [15:0] a, e);
		exp_rd.push_back(e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		@(negedge core_clk);
	endtask
	task automatic complete_run();
		n_mismatch += exp_rd.size() + exp_q.size();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		#1;
		cyc++;
		if (cyc > 3000) begin
			n_mismatch++;
			complete_run();
		end
		if (rvalid === 1'b1) cmp_rd(exp_rd.size() ? exp_rd.pop_front() : 16'hxxxx);
		if (q !== lq) cmp_q(exp_q.size() ? exp_q.pop_front() : 11'hxxx);
		lq = q;
	end
	initial begin
		repeat (10) @(negedge core_clk);
		nrst = 1'b1;
		@(negedge core_clk);
		rd(pin_qual_pkg::SYSTEM_CONTROL_TWO_ADDR, {8'h00, pin_qual_pkg::SCR2_RESET});
		rd(16'h7018, 16'h0000);
		for (int m = 0; m < 2; m++) begin
			lfsr = nxt(lfsr);
			w = {lfsr[15:7], m[0], lfsr[5], 1'b0, lfsr[3:0]};
			wr(pin_qual_pkg::SYSTEM_CONTROL_TWO_ADDR, w);
			rd(pin_qual_pkg::SYSTEM_CONTROL_TWO_ADDR, {8'h00, w[7:0]});
			n = m ? int'(pin_qual_pkg::LONG_EDGES) : int'(pin_qual_pkg::SHORT_EDGES);
			repeat (4) begin
				lfsr = nxt(lfsr);
				v = lfsr[10:0];
				if (v !== el) exp_q.push_back(v);
				el = v;
				i_pin_driver_model.drive(v, n + 4);
				i_pin_driver_model.drive(~v, n - 1);
				i_pin_driver_model.drive(v, n + 4);
				rd(pin_qual_pkg::COMPARE_CONTROL_A_ADDR, {7'h00, v[9], 8'h00});
				rd(pin_qual_pkg::COMPARE_CONTROL_B_ADDR, {7'h00, v[10], 8'h00});
			end
			$display("filter mode %0d done", m);
		end
		// ce low must freeze the bank however long the pins move
		ce = 1'b0;
		i_pin_driver_model.drive(~el, 20);
		cmp_q(el);
		exp_q.push_back(~el);
		ce = 1'b1;
		el = ~el;
		i_pin_driver_model.drive(el, 20);
		$display("clock enable freeze done");
		complete_run();
	end
endmodule
